// [rtl/nvm_pkg.sv]
// constants and types shared by the nvm erase/write controller
// assumes a 40 MHz core clock and an ahb-lite register port
package nvm_pkg;
   // ==========================================
   // types
   typedef logic [7:0] byte_t; // one data byte
   // ==========================================
   // register indices, byte address is index times four
   localparam logic [7:0] IDX_PTR = 8'hc6; // byte pointer register
   localparam logic [7:0] IDX_KEY = 8'hc7; // unlock key register
   localparam logic [7:0] IDX_CTRL = 8'hc8; // operation control register
   localparam logic [7:0] IDX_DATA = 8'hcf; // write byte register
   // ==========================================
   // control register fields
   localparam int ERASE_POS = 7; // page erase bit
   localparam int WRITE_POS = 6; // byte write bit
   localparam byte_t CTRL_RST = 8'h00; // control reset value
   localparam byte_t DATA_RST = 8'h00; // write byte reset value
   localparam byte_t PTR_RST = 8'h00; // pointer reset value
   // ==========================================
   // unlock sequence
   localparam byte_t KEY_FIRST = 8'haa; // first key byte
   localparam byte_t KEY_SECOND = 8'h55; // second key byte
   // ==========================================
   // array geometry
   localparam int PAGES = 4; // pages in the array
   localparam int PAGE_BYTES = 64; // bytes per page
   localparam int ARRAY_BYTES = PAGES * PAGE_BYTES;
   localparam byte_t ERASED = 8'hff; // erased byte value
   localparam logic [5:0] LAST_OFS = 6'h3f; // last offset in a page
   // ==========================================
   // timing
   localparam int CLK_NS = 25; // core clock period
   localparam int MC_CLKS = 4; // clocks per machine cycle
   localparam int WIN_MC = 3; // window length in machine cycles
   localparam int WIN_CYC = WIN_MC * MC_CLKS;
   localparam int ERASE_NS = 5000; // settle time after page erase
   localparam int PROG_NS = 1000; // settle time after byte write
   localparam int ERASE_CYC = (ERASE_NS + CLK_NS - 1) / CLK_NS;
   localparam int PROG_CYC = (PROG_NS + CLK_NS - 1) / CLK_NS;
endpackage

// [rtl/nvm_array.sv]
// 256 x 8 storage for the nvm data area
// assumes one writer and one reader, read data registered
module nvm_array (
   // clock
   input wire logic mclk,
   // write port
   input wire logic we,
   input wire logic [7:0] waddr,
   input wire nvm_pkg::byte_t wdata,
   // read port
   input wire logic [7:0] raddr,
   output nvm_pkg::byte_t rdata
);
   import nvm_pkg::*;
   // ==========================================
   // storage, no reset: contents survive like real nvm
   byte_t mem [ARRAY_BYTES];

   // write port
   always_ff @(posedge mclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // registered read port
   always_ff @(posedge mclk) begin
      rdata <= mem[raddr];
   end
endmodule

// [rtl/unlock_key.sv]
// two-write unlock sequence that opens a short write window
// assumes wr_any pulses once for every register write
module unlock_key (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // register writes
   input wire logic wr_any,
   input wire logic wr_key,
   input wire nvm_pkg::byte_t wdata,
   // window
   output logic win_open
);
   import nvm_pkg::*;
   // ==========================================
   // sequence state
   typedef enum logic [0:0] {K_IDLE, K_GOT_FIRST} key_st_t;
   key_st_t st_q; // sequence state
   logic [4:0] win_cnt_q; // clocks left in window
   logic second_ok; // valid second key write

   assign second_ok = (st_q == K_GOT_FIRST) && wr_key && (wdata == KEY_SECOND);

   // sequence tracking: any other write after the first key aborts
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_q <= K_IDLE;
      end else if (wr_any) begin
         case (st_q)
            K_IDLE: begin
               if (wr_key && wdata == KEY_FIRST) begin // RL1
                  st_q <= K_GOT_FIRST;
               end
            end
            K_GOT_FIRST: begin
               // second write decides, right or wrong
               st_q <= K_IDLE; // RL2 RL16
            end
            default: st_q <= K_IDLE;
         endcase
      end
   end

   // window counter, reloaded by a fresh sequence
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         win_cnt_q <= 5'h00;
      end else if (second_ok) begin
         win_cnt_q <= 5'(WIN_CYC); // RL3
      end else if (win_cnt_q != 5'h00) begin
         win_cnt_q <= win_cnt_q - 5'h01;
      end
   end

   assign win_open = (win_cnt_q != 5'h00); // RL3

   // ==========================================
   // checks
   property p_win_len;
      @(posedge mclk) disable iff (sys_rst)
      $rose(win_open) && !wr_any |-> win_open [*8] ##1 win_open [*4] ##1 !win_open;
   endproperty
   a_win_len: assert property (p_win_len) else $error("window length wrong"); // RL3

   property p_key_opens;
      @(posedge mclk) disable iff (sys_rst)
      second_ok |=> win_open;
   endproperty
   a_key_opens: assert property (p_key_opens) else $error("key did not open"); // RL2

   property p_abort;
      @(posedge mclk) disable iff (sys_rst)
      (st_q == K_GOT_FIRST) && wr_any && !second_ok && !win_open |=> !win_open;
   endproperty
   a_abort: assert property (p_abort) else $error("bad key opened window"); // RL16
endmodule

// [rtl/nvm_page_erase_write_ctrl.sv]
// nvm page erase and byte write controller with ahb-lite registers
// assumes a single ahb-lite master and a core that honours cpu_stall
// Function
// [RL1] software writes first key byte aah
// [RL2] very next write must be 55h
// [RL3] window stays open three machine cycles
// [RL4] page erase fills page with ffh
// [RL5] four pages of 64 bytes each
// [RL6] erase page taken from byte pointer
// [RL7] core held while erase runs
// [RL8] core released after erase ends
// [RL9] byte write programs data, core held
// [RL10] core released after byte write ends
// [RL11] page is top two pointer bits
// [RL12] reduced variant has pages 0, 1 only
// [RL13] write byte register supplies programmed byte
// [RL14] stored data read via code read path
// [RL15] pointer gives low address byte
// [RL16] locked writes ignored, wrong key aborts
// [RL17] idle when bits clear, cleared when done
//
// Added by the designer: register access over AHB-Lite.
module nvm_page_erase_write_ctrl #(
   parameter bit REDUCED = 1'b0 // only pages 0 and 1 exist
) (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // core stall
   output logic cpu_stall,
   // code read instruction path
   input wire logic [7:0] code_rd_addr,
   output nvm_pkg::byte_t code_rd_data
);
   import nvm_pkg::*;
   // ==========================================
   // decode helpers
   // word index of a byte address
   function automatic logic [7:0] idx_of(input logic [31:0] a);
      return a[9:2];
   endfunction

   // address falls inside the register window
   function automatic logic in_map(input logic [31:0] a);
      return (a[31:10] == 22'h000000) && (a[1:0] == 2'b00);
   endfunction

   // ==========================================
   // bus state
   logic take; // address phase accepted
   logic wr_pend_q; // write data phase pending
   logic [7:0] wr_idx_q; // index of pending write
   logic [31:0] hrdata_q; // registered read data
   logic wr_any; // write data phase now
   logic wr_ptr; // pointer write
   logic wr_key; // key write
   logic wr_ctrl; // control write
   logic wr_data; // write byte write

   // ==========================================
   // register state
   byte_t byte_pointer_q; // byte pointer register
   byte_t write_byte_q; // write byte register
   logic page_erase_bit_q; // erase in progress
   logic byte_write_bit_q; // write in progress
   logic win_open; // protected window open

   // ==========================================
   // engine state
   typedef enum logic [1:0] {S_IDLE, S_ERASE, S_PROG, S_WAIT} eng_st_t;
   eng_st_t st_q; // engine state
   logic [1:0] page_q; // page being erased
   logic [5:0] ofs_q; // erase offset in page
   logic [7:0] wait_q; // settle counter
   logic accept; // protected write accepted
   logic start_erase; // erase starts
   logic start_prog; // byte write starts
   logic done; // operation finished
   logic page_ok; // selected page exists
   logic mem_we; // array write strobe
   logic [7:0] mem_waddr; // array write address
   byte_t mem_wdata; // array write data

   // ==========================================
   // ahb-lite address phase
   assign take = hsel && htrans[1] && hready;
   assign hreadyout = 1'b1; // zero wait states
   assign hresp = 1'b0; // always okay
   assign hrdata = hrdata_q;

   // capture a write for its data phase
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         wr_pend_q <= 1'b0;
         wr_idx_q <= 8'h00;
      end else begin
         wr_pend_q <= take && hwrite && in_map(haddr);
         wr_idx_q <= idx_of(haddr);
      end
   end

   // read data prepared in the address phase
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         hrdata_q <= 32'h00000000;
      end else if (take && !hwrite) begin
         if (!in_map(haddr)) begin
            hrdata_q <= 32'h00000000; // unmapped reads zero
         end else begin
            case (idx_of(haddr))
               IDX_PTR: hrdata_q <= {24'h000000, byte_pointer_q};
               IDX_DATA: hrdata_q <= {24'h000000, write_byte_q};
               IDX_CTRL: hrdata_q <= {24'h000000, page_erase_bit_q,
                                      byte_write_bit_q, 6'h00};
               default: hrdata_q <= 32'h00000000; // key is write only
            endcase
         end
      end
   end

   // data phase strobes
   assign wr_any = wr_pend_q;
   assign wr_ptr = wr_pend_q && (wr_idx_q == IDX_PTR);
   assign wr_key = wr_pend_q && (wr_idx_q == IDX_KEY);
   assign wr_ctrl = wr_pend_q && (wr_idx_q == IDX_CTRL);
   assign wr_data = wr_pend_q && (wr_idx_q == IDX_DATA);

   // ==========================================
   // unlock window
   unlock_key u_key (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .wr_any(wr_any),
      .wr_key(wr_key),
      .wdata(hwdata[7:0]),
      .win_open(win_open)
   );

   // ==========================================
   // plain registers
   // pointer names the low address byte of the data area
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         byte_pointer_q <= PTR_RST;
      end else if (wr_ptr) begin
         byte_pointer_q <= hwdata[7:0]; // RL15
      end
   end

   // byte to program
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         write_byte_q <= DATA_RST;
      end else if (wr_data) begin
         write_byte_q <= hwdata[7:0]; // RL13
      end
   end

   // ==========================================
   // control register
   // page comes from the top pointer bits; reduced parts lack pages 2, 3
   assign page_ok = !(REDUCED && byte_pointer_q[7]); // RL12 RL11
   // locked or busy writes are dropped silently
   assign accept = wr_ctrl && win_open && (st_q == S_IDLE) && page_ok; // RL16
   // erase wins when both bits are written together
   assign start_erase = accept && hwdata[ERASE_POS]; // RL4
   assign start_prog = accept && !hwdata[ERASE_POS] && hwdata[WRITE_POS]; // RL9
   assign done = (st_q == S_WAIT) && (wait_q == 8'h00);

   // operation bits: set on start, cleared by hardware at the end
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         page_erase_bit_q <= CTRL_RST[ERASE_POS];
         byte_write_bit_q <= CTRL_RST[WRITE_POS];
      end else if (start_erase) begin
         page_erase_bit_q <= 1'b1;
      end else if (start_prog) begin
         byte_write_bit_q <= 1'b1;
      end else if (done) begin
         page_erase_bit_q <= 1'b0; // RL17
         byte_write_bit_q <= 1'b0; // RL17
      end
   end

   // ==========================================
   // engine
   // erase walks one byte per clock, then both ops settle
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_q <= S_IDLE;
      end else begin
         case (st_q)
            S_IDLE: begin
               if (start_erase) begin
                  st_q <= S_ERASE;
               end else if (start_prog) begin
                  st_q <= S_PROG;
               end
            end
            S_ERASE: begin
               if (ofs_q == LAST_OFS) begin
                  st_q <= S_WAIT;
               end
            end
            S_PROG: st_q <= S_WAIT;
            S_WAIT: begin
               if (wait_q == 8'h00) begin
                  st_q <= S_IDLE; // RL8 RL10
               end
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end

   // page latched at start so pointer writes cannot move it
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         page_q <= 2'b00;
      end else if (start_erase) begin
         page_q <= byte_pointer_q[7:6]; // RL6 RL11
      end
   end

   // erase offset within the page
   always_ff @(posedge mclk) begin
      if (sys_rst || st_q != S_ERASE) begin
         ofs_q <= 6'h00;
      end else begin
         ofs_q <= ofs_q + 6'h01;
      end
   end

   // settle counter loaded as the array writes finish
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         wait_q <= 8'h00;
      end else if (st_q == S_ERASE && ofs_q == LAST_OFS) begin
         wait_q <= 8'(ERASE_CYC - 1);
      end else if (st_q == S_PROG) begin
         wait_q <= 8'(PROG_CYC - 1);
      end else if (wait_q != 8'h00) begin
         wait_q <= wait_q - 8'h01;
      end
   end

   // core held from start to the end of settling
   assign cpu_stall = (st_q != S_IDLE); // RL7 RL9

   // ==========================================
   // array access
   always_comb begin
      mem_we = 1'b0; // RL17
      mem_waddr = byte_pointer_q;
      mem_wdata = write_byte_q; // RL13
      if (st_q == S_ERASE) begin
         mem_we = 1'b1;
         mem_waddr = {page_q, ofs_q};
         mem_wdata = ERASED; // RL4
      end else if (st_q == S_PROG) begin
         mem_we = 1'b1; // RL9
      end
   end

   // four pages of 64 bytes, read by the code read path
   nvm_array u_array ( // RL5
      .mclk(mclk),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(mem_wdata),
      .raddr(code_rd_addr),
      .rdata(code_rd_data) // RL14
   );

   // ==========================================
   // checks
   property p_erase_stall;
      @(posedge mclk) disable iff (sys_rst)
      start_erase |=> cpu_stall [*8];
   endproperty
   a_erase_stall: assert property (p_erase_stall) else $error("erase not stalled"); // RL7

   property p_erase_ff;
      @(posedge mclk) disable iff (sys_rst)
      (st_q == S_ERASE) |-> mem_we && (mem_wdata == ERASED);
   endproperty
   a_erase_ff: assert property (p_erase_ff) else $error("erase value wrong"); // RL4

   property p_erase_page;
      @(posedge mclk) disable iff (sys_rst)
      start_erase |=> ##1 mem_waddr[7:6] == $past(byte_pointer_q[7:6], 2);
   endproperty
   a_erase_page: assert property (p_erase_page) else $error("wrong page"); // RL6

   property p_prog_data;
      @(posedge mclk) disable iff (sys_rst)
      start_prog |=> mem_we && (mem_wdata == write_byte_q);
   endproperty
   a_prog_data: assert property (p_prog_data) else $error("bad program byte"); // RL9

   property p_release;
      @(posedge mclk) disable iff (sys_rst)
      $fell(cpu_stall) |-> !page_erase_bit_q && !byte_write_bit_q;
   endproperty
   a_release: assert property (p_release) else $error("bits left set"); // RL17

   property p_prog_len;
      @(posedge mclk) disable iff (sys_rst)
      start_prog |=> cpu_stall ##41 !cpu_stall;
   endproperty
   a_prog_len: assert property (p_prog_len) else $error("write stall wrong"); // RL10

   property p_reduced;
      @(posedge mclk) disable iff (sys_rst)
      REDUCED && mem_we |-> !mem_waddr[7];
   endproperty
   a_reduced: assert property (p_reduced) else $error("absent page written"); // RL12

   property p_locked;
      @(posedge mclk) disable iff (sys_rst)
      wr_ctrl && !win_open && !cpu_stall |=> !cpu_stall;
   endproperty
   a_locked: assert property (p_locked) else $error("locked write took"); // RL16
endmodule

// [tb/cpu_core_model.sv]
// core model: a program counter that the controller can freeze
// assumes cpu_stall covers the whole of an erase or byte write
module cpu_core_model (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // stall from the controller
   input wire logic cpu_stall,
   // code read request from the bench
   input wire logic [7:0] fetch_addr,
   // core outputs
   output logic [15:0] pc_q,
   output logic [7:0] code_rd_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // program counter
   // held on the stalled instruction, steps on once released
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pc_q <= 16'h0000;
      end else if (!cpu_stall) begin
         pc_q <= pc_q + 16'h0001;
      end
   end
   // ==========================================
   // code read path
   // stored bytes come back only through the code read address, never a register
   always_ff @(posedge mclk) begin
      code_rd_addr <= fetch_addr;
   end
endmodule

// [tb/nvm_page_erase_write_ctrl_tb_top.sv]
// bench for the nvm erase/write controller: ahb-lite tasks and sequences
// assumes zero-wait slave; the core model sits on the stall line
module nvm_page_erase_write_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import nvm_pkg::*;
   // ==========================================
   // signals
   logic mclk, sys_rst, hsel, hwrite, hreadyout, hresp, cpu_stall, stall_red;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] code_rd_addr, fetch_addr;
   byte_t code_rd_data;
   logic [15:0] pc_q;
   int failures, num_checks;
   logic [31:0] d;
   // ==========================================
   // design and partner
   nvm_page_erase_write_ctrl #(.REDUCED(1'b0)) u_dut (
      .mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cpu_stall(cpu_stall),
      .code_rd_addr(code_rd_addr), .code_rd_data(code_rd_data));
   cpu_core_model u_core (
      .mclk(mclk), .sys_rst(sys_rst), .cpu_stall(cpu_stall),
      .fetch_addr(fetch_addr), .pc_q(pc_q), .code_rd_addr(code_rd_addr));
   // reduced part on the same bus: it must refuse work on pages 2 and 3
   nvm_page_erase_write_ctrl #(.REDUCED(1'b1)) u_dut_red (
      .mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(), .hresp(), .hrdata(), .cpu_stall(stall_red),
      .code_rd_addr(code_rd_addr), .code_rd_data());
   // ==========================================
   // clock
   initial begin
      mclk = 1'b0;
      forever #(CLK_NS / 2.0) mclk = ~mclk;
   end
   // ==========================================
   // helpers
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t value mismatch seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one bus transfer; the address phase is held until hready is seen high
   task automatic xfer(input logic [7:0] idx, input logic wr, input byte_t wd);
      @(posedge mclk);
      hsel <= 1'b1;
      haddr <= {22'h000000, idx, 2'b00};
      hwrite <= wr;
      htrans <= 2'b10;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h000000, wd};
      do @(posedge mclk); while (hreadyout !== 1'b1);
      d = hrdata; // read data taken at the closing edge
   endtask
   task automatic wr(input logic [7:0] idx, input byte_t wd);
      xfer(idx, 1'b1, wd);
   endtask
   task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
      xfer(idx, 1'b0, 8'h00);
      chk(d, exp);
      chk({31'h0, hresp}, 32'h0);
   endtask
   task automatic unlock();
      wr(IDX_KEY, KEY_FIRST);
      wr(IDX_KEY, KEY_SECOND);
   endtask
   // array bytes are fetched through the core's code read path
   task automatic code_chk(input logic [7:0] a, input byte_t exp);
      @(posedge mclk);
      fetch_addr <= a;
      repeat (3) @(posedge mclk);
      chk({24'h000000, code_rd_data}, {24'h000000, exp});
   endtask
   // a refused control write must leave the core running
   task automatic no_op();
      repeat (4) @(posedge mclk);
      #1;
      chk({31'h0, cpu_stall}, 32'h0);
   endtask
   // measures the stall and checks the core is frozen, then released
   task automatic op_wait(input int exp, input logic exp_red);
      int n;
      logic [15:0] pc0;
      n = 0;
      // let the edge that started the operation settle, so it is counted too
      #1;
      while (cpu_stall !== 1'b1 && n < 8) begin
         @(posedge mclk);
         #1;
         n++;
      end
      pc0 = pc_q;
      chk({31'h0, stall_red}, {31'h0, exp_red});
      n = 0;
      while (cpu_stall === 1'b1 && n < 2000) begin
         @(posedge mclk);
         #1;
         n++;
      end
      chk(n, exp);
      chk({16'h0, pc_q}, {16'h0, pc0});
      @(posedge mclk);
      #1;
      chk({16'h0, pc_q}, {16'h0, pc0 + 16'h0001});
   endtask
   task automatic give_verdict();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ==========================================
   // watchdog, well beyond three erases and the short sequences
   initial begin
      #(CLK_NS * 6000);
      failures++;
      give_verdict();
   end
   // ==========================================
   // main sequence
   initial begin
      sys_rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      fetch_addr = 8'h00;
      failures = 0;
      num_checks = 0;
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      // reset values, write-only key, an unused index inside the register window
      rd_chk(IDX_PTR, {24'h0, PTR_RST});
      rd_chk(IDX_DATA, {24'h0, DATA_RST});
      rd_chk(IDX_CTRL, {24'h0, CTRL_RST});
      rd_chk(IDX_KEY, 32'h0);
      rd_chk(8'h10, 32'h0);
      // locked control write is ignored
      wr(IDX_PTR, 8'h3f);
      wr(IDX_DATA, 8'h12);
      rd_chk(IDX_DATA, 32'h12);
      wr(IDX_CTRL, 8'h40);
      no_op();
      // another write between the two keys aborts
      wr(IDX_KEY, KEY_FIRST);
      wr(IDX_DATA, 8'h12);
      wr(IDX_KEY, KEY_SECOND);
      wr(IDX_CTRL, 8'h40);
      no_op();
      // a wrong second key aborts
      wr(IDX_KEY, KEY_FIRST);
      wr(IDX_KEY, 8'h33);
      wr(IDX_KEY, KEY_SECOND);
      wr(IDX_CTRL, 8'h40);
      no_op();
      // the window has closed after three machine cycles
      unlock();
      repeat (WIN_CYC) @(posedge mclk);
      wr(IDX_CTRL, 8'h40);
      no_op();
      // byte write at the last byte of page 0
      unlock();
      wr(IDX_CTRL, 8'h40);
      op_wait(PROG_CYC + 1, 1'b1);
      rd_chk(IDX_CTRL, 32'h0);
      code_chk(8'h3f, 8'h12);
      // byte write at the first byte of page 1
      wr(IDX_PTR, 8'h40);
      wr(IDX_DATA, 8'h5a);
      unlock();
      wr(IDX_CTRL, 8'h40);
      op_wait(PROG_CYC + 1, 1'b1);
      code_chk(8'h40, 8'h5a);
      // erase pages 1 to 3 from a mid-page pointer; both bits set means erase only
      for (int p = 1; p < PAGES; p++) begin
         wr(IDX_PTR, {p[1:0], 6'h05});
         unlock();
         wr(IDX_CTRL, (p == 2) ? 8'hc0 : 8'h80);
         rd_chk(IDX_CTRL, 32'h80);
         // the busy readback above used three of the stalled cycles
         op_wait(PAGE_BYTES + ERASE_CYC - 3, p < 2);
         rd_chk(IDX_CTRL, 32'h0);
         code_chk({p[1:0], 6'h00}, ERASED);
         code_chk({p[1:0], LAST_OFS}, ERASED);
      end
      code_chk(8'h3f, 8'h12);
      give_verdict();
   end
endmodule
